// ===== csrf_map.vh
/*
 * Register offsets, field positions, reset values and ALU operation codes for
 * the core status and power-control register bank.
 * Assumes a 9-bit data address space of four banks of 128 addresses each.
 */
`ifndef CSRF_MAP_VH
`define CSRF_MAP_VH

// Data address space.
`define CSRF_ADDR_W          9
`define CSRF_BANK_OFS_W      7
`define CSRF_DATA_W          8

// Register offsets.
`define CSRF_STATUS_OFS      7'h03
`define CSRF_POWER_CONTROL_RESET_FLAGS_ADDR       9'h08e

// Status register fields.
`define CSRF_ST_IND_BANK     7
`define CSRF_ST_DIR_HI       6
`define CSRF_ST_DIR_LO       5
`define CSRF_ST_WDT_EXP      4
`define CSRF_ST_PWRDN        3
`define CSRF_ST_ZERO         2
`define CSRF_ST_NIB_CARRY    1
`define CSRF_ST_CARRY        0
`define CSRF_ST_RESET        8'h18

// Power-control register fields.
`define CSRF_PC_OSC_FAST     3
`define CSRF_PC_POR          1
`define CSRF_PC_BOR          0
`define CSRF_PC_RESET        8'h08
`define CSRF_PC_IMPL_MASK    8'h0b

// ALU operation codes.
`define CSRF_OP_W            3
`define CSRF_OP_ADD          3'h0
`define CSRF_OP_SUB          3'h1
`define CSRF_OP_RLF          3'h2
`define CSRF_OP_RRF          3'h3
`define CSRF_OP_ZONLY        3'h4

`endif

// ===== csrf_core_status.v
/*
 * Core status register and power-control register of a small 8-bit core,
 * with the ALU flag generation, the bank select logic and the reset flags.
 * Assumes every input is synchronous to clk_sys and that the core drives
 * the register port and the ALU operation in the same cycle when an
 * instruction both computes flags and writes its result to a register.
 */
`include "csrf_map.vh"
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Flag-updating instruction writing status keeps ALU values of the flags it updates; write data sets none of zero, nibble carry, carry.
// - Watchdog expiry and powerdown flags cannot be changed by register writes.
// - Clear-file on status zeroes upper three bits, sets zero, keeps others.
// - Indirect bank select bit 7 picks banks 2,3 when set, 0,1 when clear.
// - Direct bank select bits 6-5 pick bank 0 to 3, 128 addresses each.
// - Watchdog expiry flag reads 1 after power-up, refresh or sleep; 0 on expiry.
// - Powerdown flag reads 1 after power-up or refresh, 0 after sleep.
// - Nibble carry is carry out of bit 3; borrow polarity inverted.
// - Carry is carry out of bit 7 for add and subtract; borrow inverted.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out of the source.
// - Status answers at its offset in all four banks.
// - Oscillator speed bit 3 selects fast rate when set, slow when clear.
// - Power-on flag cleared by power-on reset, stays clear until written 1.
// - Brownout flag cleared by brownout reset, stays clear until written 1.
// - With brownout detector disabled the brownout flag follows no rule.
// - Unimplemented power-control bits 7-4 and 2 read as zero.
module csrf_core_status #(
	parameter DATA_W = `CSRF_DATA_W,
	parameter ADDR_W = `CSRF_ADDR_W
) (
	// Clock and reset.
	input  wire              clk_sys,
	input  wire              rst_b,
	// Register port.
	input  wire [ADDR_W-1:0] reg_addr,
	input  wire [DATA_W-1:0] reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [DATA_W-1:0] reg_rdata_q,
	// ALU operation.
	input  wire              alu_valid,
	input  wire [2:0]        alu_op,
	input  wire [DATA_W-1:0] alu_a,
	input  wire [DATA_W-1:0] alu_b,
	output reg  [DATA_W-1:0] alu_result_q,
	// Power and reset events.
	input  wire              watchdog_refresh_instruction,
	input  wire              sleep_instruction,
	input  wire              watchdog_expiry,
	input  wire              power_on_event,
	input  wire              brownout_event,
	input  wire              brownout_detector_enable,
	// Data addressing.
	input  wire              indirect_access,
	input  wire [6:0]        direct_offset,
	input  wire [7:0]        indirect_pointer,
	output reg  [ADDR_W-1:0] data_addr_q,
	// Status outputs.
	output reg  [DATA_W-1:0] status_q,
	output reg               internal_osc_speed_select_q,
	output reg               por_flag_q,
	output reg               brownout_flag_q
);

	//////////////////////////////////////////////////////////////////////////
	// Address decode.

	wire                     sel_status;
	wire                     sel_power_control_reset_flags;
	wire                     wr_status;
	wire                     wr_power_control_reset_flags;

	assign sel_status = (reg_addr[`CSRF_BANK_OFS_W-1:0] == `CSRF_STATUS_OFS);
	assign sel_power_control_reset_flags   = (reg_addr == `CSRF_POWER_CONTROL_RESET_FLAGS_ADDR);
	assign wr_status  = reg_wr & sel_status;
	assign wr_power_control_reset_flags    = reg_wr & sel_power_control_reset_flags;

	//////////////////////////////////////////////////////////////////////////
	// ALU flag generation.

	reg  [DATA_W-1:0]        alu_res_d;
	reg  [DATA_W-1:0]        sub_operand;
	reg  [DATA_W:0]          full_sum;
	reg  [4:0]               nib_sum;
	reg                      carry_d;
	reg                      nib_carry_d;
	reg                      zero_d;
	reg                      upd_carry;
	reg                      upd_nib_carry;
	reg                      upd_zero;

	always @* begin
		sub_operand   = ~alu_b;
		full_sum      = 9'h000;
		nib_sum       = 5'h00;
		alu_res_d     = alu_a;
		carry_d       = status_q[`CSRF_ST_CARRY];
		nib_carry_d   = status_q[`CSRF_ST_NIB_CARRY];
		upd_carry     = 1'b0;
		upd_nib_carry = 1'b0;
		upd_zero      = 1'b0;
		case (alu_op)
			`CSRF_OP_ADD: begin
				full_sum      = {1'b0, alu_a} + {1'b0, alu_b};
				nib_sum       = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
				alu_res_d     = full_sum[DATA_W-1:0];
				carry_d       = full_sum[DATA_W];
				nib_carry_d   = nib_sum[4];
				upd_carry     = 1'b1;
				upd_nib_carry = 1'b1;
				upd_zero      = 1'b1;
			end
			`CSRF_OP_SUB: begin
				full_sum      = {1'b0, alu_a} + {1'b0, sub_operand} + 9'h001;
				nib_sum       = {1'b0, alu_a[3:0]} + {1'b0, sub_operand[3:0]} + 5'h01;
				alu_res_d     = full_sum[DATA_W-1:0];
				carry_d       = full_sum[DATA_W];
				nib_carry_d   = nib_sum[4];
				upd_carry     = 1'b1;
				upd_nib_carry = 1'b1;
				upd_zero      = 1'b1;
			end
			`CSRF_OP_RLF: begin
				alu_res_d = {alu_a[DATA_W-2:0], status_q[`CSRF_ST_CARRY]};
				carry_d   = alu_a[DATA_W-1];
				upd_carry = 1'b1;
			end
			`CSRF_OP_RRF: begin
				alu_res_d = {status_q[`CSRF_ST_CARRY], alu_a[DATA_W-1:1]};
				carry_d   = alu_a[0];
				upd_carry = 1'b1;
			end
			`CSRF_OP_ZONLY: begin
				alu_res_d = alu_a;
				upd_zero  = 1'b1;
			end
			default: begin
				alu_res_d = alu_a;
			end
		endcase
		zero_d = (alu_res_d == 8'h00);
	end

	//////////////////////////////////////////////////////////////////////////
	// Status register next value.

	reg  [DATA_W-1:0]        status_d;

	always @* begin
		status_d = status_q;
		if (wr_status) begin
			status_d[`CSRF_ST_IND_BANK] = reg_wdata[`CSRF_ST_IND_BANK];
			status_d[`CSRF_ST_DIR_HI]   = reg_wdata[`CSRF_ST_DIR_HI];
			status_d[`CSRF_ST_DIR_LO]   = reg_wdata[`CSRF_ST_DIR_LO];
			if (!(alu_valid && (upd_zero || upd_nib_carry || upd_carry))) begin
				status_d[`CSRF_ST_ZERO]      = reg_wdata[`CSRF_ST_ZERO];
				status_d[`CSRF_ST_NIB_CARRY] = reg_wdata[`CSRF_ST_NIB_CARRY];
				status_d[`CSRF_ST_CARRY]     = reg_wdata[`CSRF_ST_CARRY];
			end
		end
		if (alu_valid) begin
			if (upd_zero) begin
				status_d[`CSRF_ST_ZERO] = zero_d;
			end
			if (upd_nib_carry) begin
				status_d[`CSRF_ST_NIB_CARRY] = nib_carry_d;
			end
			if (upd_carry) begin
				status_d[`CSRF_ST_CARRY] = carry_d;
			end
		end
		if (watchdog_refresh_instruction) begin
			status_d[`CSRF_ST_WDT_EXP] = 1'b1;
			status_d[`CSRF_ST_PWRDN]   = 1'b1;
		end
		if (sleep_instruction) begin
			status_d[`CSRF_ST_WDT_EXP] = 1'b1;
			status_d[`CSRF_ST_PWRDN]   = 1'b0;
		end
		if (watchdog_expiry) begin
			status_d[`CSRF_ST_WDT_EXP] = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Power-control register next value.

	reg                      osc_fast_d;
	reg                      por_flag_d;
	reg                      bor_flag_d;

	always @* begin
		osc_fast_d = internal_osc_speed_select_q;
		por_flag_d = por_flag_q;
		bor_flag_d = brownout_flag_q;
		if (wr_power_control_reset_flags) begin
			osc_fast_d = reg_wdata[`CSRF_PC_OSC_FAST];
			por_flag_d = reg_wdata[`CSRF_PC_POR];
			bor_flag_d = reg_wdata[`CSRF_PC_BOR];
		end
		if (power_on_event) begin
			por_flag_d = 1'b0;
		end
		if (brownout_event && brownout_detector_enable) begin
			bor_flag_d = 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Read data.

	reg  [DATA_W-1:0]        rdata_d;
	reg  [DATA_W-1:0]        power_control_reset_flags_view;

	always @* begin
		power_control_reset_flags_view = 8'h00;
		power_control_reset_flags_view[`CSRF_PC_OSC_FAST] = internal_osc_speed_select_q;
		power_control_reset_flags_view[`CSRF_PC_POR]      = por_flag_q;
		power_control_reset_flags_view[`CSRF_PC_BOR]      = brownout_flag_q;
		power_control_reset_flags_view = power_control_reset_flags_view & `CSRF_PC_IMPL_MASK;
		rdata_d   = 8'h00;
		if (reg_rd && sel_status) begin
			rdata_d = status_q;
		end else if (reg_rd && sel_power_control_reset_flags) begin
			rdata_d = power_control_reset_flags_view;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Data address composition.

	reg  [ADDR_W-1:0]        data_addr_d;

	always @* begin
		if (indirect_access) begin
			data_addr_d = {status_q[`CSRF_ST_IND_BANK], indirect_pointer};
		end else begin
			data_addr_d = {status_q[`CSRF_ST_DIR_HI:`CSRF_ST_DIR_LO],
				direct_offset};
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Registers.

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status_q                    <= `CSRF_ST_RESET;
			internal_osc_speed_select_q <= 1'b1;
			por_flag_q                  <= 1'b0;
			brownout_flag_q             <= 1'b0;
			reg_rdata_q                 <= 8'h00;
			alu_result_q                <= 8'h00;
			data_addr_q                 <= 9'h000;
		end else begin
			status_q                    <= status_d;
			internal_osc_speed_select_q <= osc_fast_d;
			por_flag_q                  <= por_flag_d;
			brownout_flag_q             <= bor_flag_d;
			reg_rdata_q                 <= rdata_d;
			alu_result_q                <= alu_res_d;
			data_addr_q                 <= data_addr_d;
		end
	end

endmodule

`default_nettype wire

// ===== csrf_core_status_props.sv
/* Checker for the status and power-control bank ports.
   Assumes one clock, clk_sys, and the low active reset rst_b. */
`include "csrf_map.vh"
`default_nettype none
////////////////////////////////////////
module csrf_core_status_chk (
	input wire logic       clk_sys,
	input wire logic       rst_b,
	input wire logic [8:0] reg_addr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic       alu_valid,
	input wire logic [2:0] alu_op,
	input wire logic [7:0] alu_a,
	input wire logic [7:0] alu_b,
	input wire logic       watchdog_refresh_instruction,
	input wire logic       sleep_instruction,
	input wire logic       watchdog_expiry,
	input wire logic       power_on_event,
	input wire logic [7:0] indirect_pointer,
	input wire logic       indirect_access,
	input wire logic [8:0] data_addr_q,
	input wire logic [7:0] status_q,
	input wire logic       por_flag_q
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	wire logic [8:0] add_s = {1'b0, alu_a} + {1'b0, alu_b};
	wire logic [8:0] sub_s = {1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001;
	logic            c_q;
	logic [8:0]      ind_q;
	always_ff @(posedge clk_sys) begin
		c_q <= alu_op == 3'h2 ? alu_a[7] : alu_op == 3'h3 ? alu_a[0] :
			alu_op == 3'h1 ? sub_s[8] : add_s[8];
		ind_q <= {status_q[7], indirect_pointer};
	end
	AST_ST_READ: assert property (reg_rd && reg_addr[6:0] == 7'h03 |=>
		reg_rdata_q == $past(status_q)) else $error("status read wrong");
	AST_PC_PAD: assert property (reg_rd && reg_addr == 9'h08e |=>
		reg_rdata_q[7:4] == 4'h0 && !reg_rdata_q[2]) else $error("power_control_reset_flags pad set");
	AST_WD_RO: assert property (!(sleep_instruction || watchdog_expiry ||
		watchdog_refresh_instruction) |=> $stable(status_q[4:3])) else $error("flag moved");
	AST_SLEEP: assert property (sleep_instruction && !watchdog_expiry |=>
		status_q[4:3] == 2'b10) else $error("sleep flags wrong");
	AST_EXPIRE: assert property (watchdog_expiry |=> !status_q[4])
		else $error("expiry flag set");
	AST_POR: assert property (power_on_event |=> !por_flag_q)
		else $error("por flag set");
	AST_CARRY: assert property (alu_valid && alu_op < 3'h4 |=>
		status_q[0] == c_q) else $error("carry wrong");
	AST_IND: assert property (indirect_access |=> data_addr_q == ind_q)
		else $error("indirect address wrong");
	cover property (sleep_instruction);
	cover property (indirect_access && status_q[7]);
	cover property (alu_valid && alu_op == 3'h1);
endmodule
bind csrf_core_status csrf_core_status_chk csrf_core_status_chk_i (.clk_sys(clk_sys),
	.rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
	.watchdog_refresh_instruction(watchdog_refresh_instruction),
	.sleep_instruction(sleep_instruction), .watchdog_expiry(watchdog_expiry),
	.power_on_event(power_on_event), .indirect_pointer(indirect_pointer),
	.indirect_access(indirect_access), .data_addr_q(data_addr_q),
	.status_q(status_q), .por_flag_q(por_flag_q));
`default_nettype wire

// ===== core_status_reset_flags_bench.sv
/* Self-checking random bench for the status and power-control bank.
   Assumes the map header and the checker are compiled before it. */
`include "csrf_map.vh"
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
////////////////////////////////////////
module core_status_reset_flags_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 0, rst_b = 0, w = 0, r = 0, v = 0, ind = 0, bde = 1;
	logic [8:0] a = 0;
	logic [7:0] d = 0, x = 0, y = 0, ptr = 0, m_st, m_pc, rexp;
	logic [6:0] ofs = 0;
	logic [2:0] op = 0;
	logic [4:0] ev = 0;
	logic [31:0] q;
	integer     seed = 32'hafaf, mismatches = 0, comparisons = 0, i;
	wire logic [7:0] rdq, st, res;
	wire logic [8:0] dadr;
	wire logic       osc, por, bor;
	always #4 clk = ~clk;
	csrf_core_status csrf_core_status_i (.clk_sys(clk), .rst_b(rst_b), .reg_addr(a),
		.reg_wdata(d), .reg_wr(w), .reg_rd(r), .reg_rdata_q(rdq), .alu_valid(v),
		.alu_op(op), .alu_a(x), .alu_b(y), .alu_result_q(res),
		.watchdog_refresh_instruction(ev[4]), .sleep_instruction(ev[3]),
		.watchdog_expiry(ev[2]), .power_on_event(ev[1]), .brownout_event(ev[0]),
		.brownout_detector_enable(bde), .indirect_access(ind), .direct_offset(ofs),
		.indirect_pointer(ptr), .data_addr_q(dadr), .status_q(st),
		.internal_osc_speed_select_q(osc), .por_flag_q(por), .brownout_flag_q(bor));
	////////////////////////////////////////
	function automatic [7:0] fr(input [2:0] o, input [7:0] p, s, input c);
		case (o)
			`CSRF_OP_ADD: fr = p + s;
			`CSRF_OP_SUB: fr = p - s;
			`CSRF_OP_RLF: fr = {p[6:0], c};
			`CSRF_OP_RRF: fr = {c, p[7:1]};
			default: fr = p;
		endcase
	endfunction
	function automatic [2:0] fl(input [2:0] o, input [7:0] p, s, input [2:0] f);
		logic [8:0] t;
		logic [4:0] n;
		t = o == `CSRF_OP_SUB ? {1'b0, p} + {1'b0, ~s} + 9'h1 : {1'b0, p} + {1'b0, s};
		n = o == `CSRF_OP_SUB ? {1'b0, p[3:0]} + {1'b0, ~s[3:0]} + 5'h1 :
			{1'b0, p[3:0]} + {1'b0, s[3:0]};
		case (o)
			`CSRF_OP_RLF: fl = {f[2:1], p[7]};
			`CSRF_OP_RRF: fl = {f[2:1], p[0]};
			`CSRF_OP_ZONLY: fl = {p == 8'h00, f[1:0]};
			default: fl = {t[7:0] == 8'h00, n[4], t[8]};
		endcase
	endfunction
	task automatic cyc(input logic tw, tr, input [8:0] ta, input [7:0] td, input logic tv,
		input [2:0] tp, input [7:0] tx, ty, input [4:0] te);
		rexp = !tr ? 8'h00 : ta[6:0] == 7'h03 ? m_st : ta == 9'h08e ? m_pc : 8'h00;
		w <= tw; r <= tr; a <= ta; d <= td; v <= tv; op <= tp; x <= tx; y <= ty; ev <= te;
		{ind, bde, ofs, ptr} <= 17'($random(seed));
		@(posedge clk);
		w <= 0; r <= 0; v <= 0; ev <= 0;
		#1;
		`CHK(dadr, ind ? {m_st[7], ptr} : {m_st[6:5], ofs})
		`CHK(rdq, rexp)
		`CHK(res, fr(tp, tx, ty, m_st[0]))
		if (tw && ta[6:0] == 7'h03) m_st = {td[7:5], m_st[4:3], tv ? m_st[2:0] : td[2:0]};
		if (tw && ta == 9'h08e) m_pc = td & `CSRF_PC_IMPL_MASK;
		if (tv) m_st[2:0] = fl(tp, tx, ty, m_st[2:0]);
		if (te[4]) m_st[4:3] = 2'b11;
		if (te[3]) m_st[4:3] = 2'b10;
		if (te[2]) m_st[4] = 1'b0;
		if (te[1]) m_pc[1] = 1'b0;
		if (te[0] && bde) m_pc[0] = 1'b0;
		`CHK(st, m_st)
		`CHK({4'h0, osc, 1'b0, por, bor}, m_pc)
		@(posedge clk);
	endtask
	task end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		m_st = `CSRF_ST_RESET;
		m_pc = `CSRF_PC_RESET;
		repeat (10) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		cyc(0, 1, 9'h183, 0, 0, 0, 0, 0, 0);
		cyc(0, 1, 9'h08e, 0, 0, 0, 0, 0, 0);
		for (i = 0; i < 4; i++) cyc(1, 0, {2'(i), 7'h03}, 8'($random(seed)), 0, 0, 0, 0, 0);
		cyc(1, 0, 9'h103, 8'h00, 1, `CSRF_OP_ZONLY, 8'h00, 8'h00, 0);
		cyc(0, 0, 0, 0, 1, `CSRF_OP_SUB, 8'h00, 8'h00, 0);
		cyc(1, 0, 9'h08e, 8'hff, 0, 0, 0, 0, 5'h02);
		for (i = 0; i < 5; i++) cyc(0, 1, 9'h083, 0, 0, 0, 0, 0, 5'h01 << i);
		$display("corner cases done");
		for (i = 0; i < 600; i++) begin
			q = $random(seed);
			cyc(q[0], q[1] & !q[0], q[3:2] == 0 ? 9'h08e : q[3:2] == 1 ? {q[5:4], 7'h03} :
				q[12:4], q[20:13], q[21], 3'(q[24:22] % 5), 8'($random(seed)),
				q[31] ? 8'h00 : q[31:24], q[27:25] == 0 ? q[4:0] : 5'h0);
		end
		$display("random traffic done");
		end_of_test;
	end
endmodule
`default_nettype wire
